/* bsp_pkg.sv */
// constants, field layouts and carrier types of the buffered serial port
// Functional notes
// - two select bits choose rate generator source
// - select bits: pin ctrl 7, rate two 13
// - clock pin used as source stops driving
// - rx pin source drives generator on tx pin
// - pin ctrl layout, read-only bits, zero reset
// - four separate frame and clock polarity bits
// - independent rx/tx timing with double buffering
// - up to 128 channels enabled per direction
// - narrow mode: partitions A and B only
// - wide mode: partitions C to H enabled
// - rx enable bit n takes channel n
// - tx enable bit n sends channel n
// - clock stop forces one word per frame
// - spi mode: rx follows tx clock and frame
// - word length 8,12,16,20,24 or 32 bits
package bsp_pkg;

// ----------------------------------------------------------------
// register map (byte addresses, one word each; enable banks eight words)
// ----------------------------------------------------------------
localparam logic [7:0] OFS_PIN = 8'h00;
localparam logic [7:0] OFS_RATE = 8'h04;
localparam logic [7:0] OFS_WORD = 8'h08;
localparam logic [7:0] OFS_RXD = 8'h0c;
localparam logic [7:0] OFS_TXD = 8'h10;
localparam logic [7:0] OFS_STAT = 8'h14;
localparam logic [7:0] OFS_RXEN = 8'h40;
localparam logic [7:0] OFS_TXEN = 8'h60;

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
localparam logic [15:0] PIN_WMASK = 16'h3f8f;
localparam logic [15:0] PIN_RST = 16'h0000;
localparam int RATE_CLKMODE_BIT = 13;
localparam logic [15:0] RATE_RST = 16'h0000;
localparam logic [8:0] WORD_RST = 9'h000;
localparam int PARTS = 8;
localparam int PART_CH = 16;

typedef struct packed {
    logic [1:0] reserved;
    logic tx_io_enable;
    logic rx_io_enable;
    logic transmit_frame_mode;
    logic receive_frame_mode;
    logic transmit_clock_mode;
    logic receive_clock_mode;
    logic enhanced_clock_select;
    logic ext_clock_pin_status;
    logic tx_data_pin_status;
    logic rx_data_pin_status;
    logic transmit_frame_polarity;
    logic receive_frame_polarity;
    logic transmit_clock_polarity;
    logic receive_clock_polarity;
} bsp_pin_t;

typedef struct packed {
    logic clock_stop_mode;
    logic tx_multichannel;
    logic rx_multichannel;
    logic tx_wide_channel_mode;
    logic rx_wide_channel_mode;
    logic unused;
    logic [2:0] word_code;
} bsp_word_t;

endpackage

/* bsp_serial_port.sv */
// buffered serial port: bus slave, rate generator, rx/tx engines
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-entry buffer with valid/ready on both sides
// ----------------------------------------------------------------
module bsp_fifo2 #(
    parameter int W = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    logic [W-1:0] mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign o_ready = (cnt_q != 2'd2);
    assign o_valid = (cnt_q != 2'd0);
    assign o_data = mem_q[rp_q];
    assign push = i_valid && o_ready;
    assign pop = i_ready && o_valid;

    // pointers and fill level
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) wp_q <= !wp_q;
            if (pop) rp_q <= !rp_q;
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end

    // storage, no reset needed
    always_ff @(posedge i_clk) begin
        if (push) mem_q[wp_q] <= i_data;
    end
endmodule

module bsp_serial_port (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_rx_clk_pin,
    output logic o_rx_clk_pin,
    output logic o_rx_clk_oe_n,
    input wire logic i_tx_clk_pin,
    output logic o_tx_clk_pin,
    output logic o_tx_clk_oe_n,
    input wire logic i_rx_fs_pin,
    output logic o_rx_fs_pin,
    output logic o_rx_fs_oe_n,
    input wire logic i_tx_fs_pin,
    output logic o_tx_fs_pin,
    output logic o_tx_fs_oe_n,
    input wire logic i_rx_data_pin,
    output logic o_tx_data_pin,
    output logic o_tx_data_oe_n
);
    import bsp_pkg::*;

    // ----------------------------------------------------------------
    // registers and declarations
    // ----------------------------------------------------------------
    bsp_pin_t pin_q;
    logic [15:0] rate_q;
    bsp_word_t word_q;
    logic [127:0] rx_en_q;
    logic [127:0] tx_en_q;
    logic rx_ovr_q;
    logic tx_und_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [4:0] s1_q, s2_q, s3_q;
    logic [7:0] srg_cnt_q;
    logic srg_clk_q;
    logic [4:0] gen_bit_q;
    logic [6:0] gen_slot_q;
    logic fs_gen_q;
    logic tx_pend_q, tx_act_q, tx_on_q;
    logic [6:0] tx_slot_q;
    logic [4:0] tx_bit_q;
    logic [31:0] tx_sh_q;
    logic rx_pend_q, rx_act_q;
    logic [6:0] rx_slot_q;
    logic [4:0] rx_bit_q;
    logic [31:0] rx_sh_q;
    logic req, stall, acc_w, acc_r, tick, wrap;
    logic srg_rise, srg_fall, tx_rise, tx_fall, rx_rise;
    logic tx_fs, rx_fs, tx_pin_src, rx_pin_src;
    logic [4:0] wl;
    logic [6:0] tx_last, rx_last, tx_next;
    logic txb_in_rdy, txb_out_vld, txb_pop;
    logic [31:0] txb_data;
    logic rxb_push, rxb_in_rdy, rxb_out_vld, rxb_pop;
    logic [31:0] rxb_data, rx_word, rd_mux;
    logic [15:0] pin_rd;
    logic rx_done;

    // word length code to index of last bit
    function automatic logic [4:0] last_bit(input logic [2:0] c);
        case (c)
            3'd0: last_bit = 5'd7;
            3'd1: last_bit = 5'd11;
            3'd2: last_bit = 5'd15;
            3'd3: last_bit = 5'd19;
            3'd4: last_bit = 5'd23;
            default: last_bit = 5'd31;
        endcase
    endfunction

    // channel enable lookup; narrow mode limits to slots 0..31
    function automatic logic ch_on(input logic [127:0] en,
            input logic [6:0] slot, input logic mc, input logic wide);
        if (!mc) ch_on = 1'b1;
        else if (!wide && slot[6:5] != 2'd0) ch_on = 1'b0;
        else ch_on = en[slot];
    endfunction

    // ----------------------------------------------------------------
    // avalon slave
    // ----------------------------------------------------------------
    assign req = i_read || i_write;
    assign stall = i_write && i_address == OFS_TXD && !txb_in_rdy;
    assign acc_w = i_write && !wait_q;
    assign acc_r = i_read && !wait_q;

    // one-cycle answer; a write to a full transmit buffer waits
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) wait_q <= 1'b1;
        else wait_q <= !(req && wait_q && !stall);
    end

    assign pin_rd = {2'b00, pin_q[13:7], 1'b0, o_tx_data_pin,
        s2_q[4], pin_q[3:0]};

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_address)
            OFS_PIN: rd_mux = {16'h0000, pin_rd};
            OFS_RATE: rd_mux = {16'h0000, rate_q};
            OFS_WORD: rd_mux = {23'h000000, word_q};
            OFS_RXD: rd_mux = rxb_data;
            OFS_STAT: rd_mux = {28'h0000000, tx_und_q, rx_ovr_q,
                rxb_out_vld, txb_in_rdy};
            default: begin
                if (i_address[7:5] == OFS_RXEN[7:5])
                    rd_mux = {16'h0000, rx_en_q[16*i_address[4:2] +: 16]};
                else if (i_address[7:5] == OFS_TXEN[7:5])
                    rd_mux = {16'h0000, tx_en_q[16*i_address[4:2] +: 16]};
            end
        endcase
    end

    // read data captured while the answer is prepared
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) rdata_q <= 32'h0000_0000;
        else if (i_read && wait_q) rdata_q <= rd_mux;
    end
    assign o_readdata = rdata_q;
    assign o_waitrequest = wait_q;

    // configuration registers; status bits of pin ctrl are not stored
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_q <= PIN_RST;
            rate_q <= RATE_RST;
            word_q <= WORD_RST;
        end else if (acc_w) begin
            if (i_address == OFS_PIN)
                pin_q <= i_writedata[15:0] & PIN_WMASK;
            if (i_address == OFS_RATE) rate_q <= i_writedata[15:0];
            if (i_address == OFS_WORD) word_q <= i_writedata[8:0];
        end
    end

    // channel enable registers, one per partition and direction
    genvar gp;
    generate
        for (gp = 0; gp < PARTS; gp++) begin : g_part
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    rx_en_q[gp*PART_CH +: PART_CH] <= 16'h0000;
                    tx_en_q[gp*PART_CH +: PART_CH] <= 16'h0000;
                end else if (acc_w && i_address[4:2] == 3'(gp)) begin
                    if (i_address[7:5] == OFS_RXEN[7:5])
                        rx_en_q[gp*PART_CH +: PART_CH] <=
                            i_writedata[15:0];
                    if (i_address[7:5] == OFS_TXEN[7:5])
                        tx_en_q[gp*PART_CH +: PART_CH] <=
                            i_writedata[15:0];
                end
            end
        end
    endgenerate

    // sticky errors, write one clears, a new event wins
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rx_ovr_q <= 1'b0;
            tx_und_q <= 1'b0;
        end else begin
            if (rx_done && !rxb_in_rdy && rxb_push) rx_ovr_q <= 1'b1;
            else if (acc_w && i_address == OFS_STAT && i_writedata[2])
                rx_ovr_q <= 1'b0;
            if (txb_pop == 1'b0 && tx_fall && tx_on_q && !txb_out_vld
                    && (tx_pend_q || (tx_act_q && tx_bit_q == wl)))
                tx_und_q <= 1'b1;
            else if (acc_w && i_address == OFS_STAT && i_writedata[3])
                tx_und_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers: rx clk, tx clk, rx fs, tx fs, rx data
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            s3_q <= 5'h00;
        end else begin
            s1_q <= {i_rx_data_pin, i_tx_fs_pin, i_rx_fs_pin,
                i_tx_clk_pin, i_rx_clk_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ----------------------------------------------------------------
    // sample rate generator
    // ----------------------------------------------------------------
    assign rx_pin_src = pin_q.enhanced_clock_select
        && !rate_q[RATE_CLKMODE_BIT];
    assign tx_pin_src = pin_q.enhanced_clock_select
        && rate_q[RATE_CLKMODE_BIT];

    // source select; the unpinned external clock gives no ticks
    always_comb begin
        case ({pin_q.enhanced_clock_select, rate_q[RATE_CLKMODE_BIT]})
            2'b01: tick = 1'b1;
            2'b10: tick = s2_q[0] && !s3_q[0];
            2'b11: tick = s2_q[1] && !s3_q[1];
            default: tick = 1'b0;
        endcase
    end

    assign srg_rise = tick && srg_cnt_q == rate_q[7:0] && !srg_clk_q;
    assign srg_fall = tick && srg_cnt_q == rate_q[7:0] && srg_clk_q;

    // divider; low byte of rate reg is half period minus one
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            srg_cnt_q <= 8'h00;
            srg_clk_q <= 1'b0;
        end else if (tick) begin
            if (srg_cnt_q == rate_q[7:0]) begin
                srg_cnt_q <= 8'h00;
                srg_clk_q <= !srg_clk_q;
            end else begin
                srg_cnt_q <= 8'(srg_cnt_q + 8'h01);
            end
        end
    end

    // internal frame pulse, one bit long, once per transmit frame
    assign wrap = gen_bit_q == wl && gen_slot_q == tx_last;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            gen_bit_q <= 5'd0;
            gen_slot_q <= 7'd0;
            fs_gen_q <= 1'b0;
        end else if (srg_fall) begin
            fs_gen_q <= wrap;
            gen_bit_q <= (gen_bit_q == wl) ? 5'd0 : 5'(gen_bit_q + 5'd1);
            if (wrap) gen_slot_q <= 7'd0;
            else if (gen_bit_q == wl)
                gen_slot_q <= 7'(gen_slot_q + 7'd1);
        end
    end

    // ----------------------------------------------------------------
    // bit timing; edges are seen two to three cycles after the pin
    // ----------------------------------------------------------------
    assign wl = last_bit(word_q.word_code);
    assign tx_last = word_q.clock_stop_mode ? 7'd0
        : !word_q.tx_multichannel ? 7'd0
        : word_q.tx_wide_channel_mode ? 7'd127 : 7'd31;
    assign rx_last = word_q.clock_stop_mode ? 7'd0
        : !word_q.rx_multichannel ? 7'd0
        : word_q.rx_wide_channel_mode ? 7'd127 : 7'd31;
    assign tx_rise = pin_q.transmit_clock_mode ? srg_rise
        : ((s2_q[1] ^ pin_q.transmit_clock_polarity)
        && !(s3_q[1] ^ pin_q.transmit_clock_polarity));
    assign tx_fall = pin_q.transmit_clock_mode ? srg_fall
        : (!(s2_q[1] ^ pin_q.transmit_clock_polarity)
        && (s3_q[1] ^ pin_q.transmit_clock_polarity));
    assign rx_rise = word_q.clock_stop_mode ? tx_rise
        : pin_q.receive_clock_mode ? srg_rise
        : ((s2_q[0] ^ pin_q.receive_clock_polarity)
        && !(s3_q[0] ^ pin_q.receive_clock_polarity));
    assign tx_fs = pin_q.transmit_frame_mode ? fs_gen_q
        : (s2_q[3] ^ pin_q.transmit_frame_polarity);
    assign rx_fs = word_q.clock_stop_mode ? tx_fs
        : pin_q.receive_frame_mode ? fs_gen_q
        : (s2_q[2] ^ pin_q.receive_frame_polarity);

    // ----------------------------------------------------------------
    // transmitter: frame seen on rise, bits launched on fall
    // ----------------------------------------------------------------
    assign tx_next = tx_pend_q ? 7'd0 : 7'(tx_slot_q + 7'd1);
    assign txb_pop = tx_fall && txb_out_vld
        && ch_on(tx_en_q, tx_next, word_q.tx_multichannel,
        word_q.tx_wide_channel_mode)
        && (tx_pend_q || (tx_act_q && tx_bit_q == wl
        && tx_slot_q != tx_last));

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tx_pend_q <= 1'b0;
            tx_act_q <= 1'b0;
            tx_on_q <= 1'b0;
            tx_slot_q <= 7'd0;
            tx_bit_q <= 5'd0;
            tx_sh_q <= 32'h0000_0000;
        end else begin
            if (tx_rise && tx_fs && !tx_act_q) tx_pend_q <= 1'b1;
            if (tx_fall) begin
                if (tx_pend_q || (tx_act_q && tx_bit_q == wl
                        && tx_slot_q != tx_last)) begin
                    tx_pend_q <= 1'b0;
                    tx_act_q <= 1'b1;
                    tx_slot_q <= tx_next;
                    tx_bit_q <= 5'd0;
                    tx_on_q <= ch_on(tx_en_q, tx_next,
                        word_q.tx_multichannel,
                        word_q.tx_wide_channel_mode);
                    tx_sh_q <= txb_pop
                        ? 32'(txb_data << (5'd31 - wl)) : 32'h0000_0000;
                end else if (tx_act_q && tx_bit_q == wl) begin
                    tx_act_q <= 1'b0;
                    tx_on_q <= 1'b0;
                end else if (tx_act_q) begin
                    tx_bit_q <= 5'(tx_bit_q + 5'd1);
                    tx_sh_q <= {tx_sh_q[30:0], 1'b0};
                end
            end
        end
    end

    // data pin undriven outside frames and in disabled slots
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_tx_data_pin <= 1'b0;
            o_tx_data_oe_n <= 1'b1;
        end else begin
            o_tx_data_pin <= tx_sh_q[31];
            o_tx_data_oe_n <= !(tx_act_q && tx_on_q);
        end
    end

    // ----------------------------------------------------------------
    // receiver: one bit data delay after the frame pulse
    // ----------------------------------------------------------------
    assign rx_done = rx_rise && rx_act_q && rx_bit_q == wl;
    assign rx_word = {rx_sh_q[30:0], s2_q[4]} & ~(32'hffff_fffe << wl);
    assign rxb_push = rx_done && ch_on(rx_en_q, rx_slot_q,
        word_q.rx_multichannel, word_q.rx_wide_channel_mode);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rx_pend_q <= 1'b0;
            rx_act_q <= 1'b0;
            rx_slot_q <= 7'd0;
            rx_bit_q <= 5'd0;
            rx_sh_q <= 32'h0000_0000;
        end else if (rx_rise) begin
            if (rx_pend_q) begin
                rx_pend_q <= 1'b0;
                rx_act_q <= 1'b1;
                rx_slot_q <= 7'd0;
                rx_bit_q <= 5'd1;
                rx_sh_q <= {31'h00000000, s2_q[4]};
            end else if (rx_act_q) begin
                rx_sh_q <= {rx_sh_q[30:0], s2_q[4]};
                if (rx_bit_q == wl) begin
                    rx_bit_q <= 5'd0;
                    rx_slot_q <= 7'(rx_slot_q + 7'd1);
                    if (rx_slot_q == rx_last) rx_act_q <= 1'b0;
                end else begin
                    rx_bit_q <= 5'(rx_bit_q + 5'd1);
                end
            end
            if (rx_fs && !rx_act_q && !rx_pend_q) rx_pend_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // double buffers between bus and engines
    // ----------------------------------------------------------------
    assign rxb_pop = acc_r && i_address == OFS_RXD;

    bsp_fifo2 #(.W(32)) u_tx_buf (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(acc_w && i_address == OFS_TXD),
        .o_ready(txb_in_rdy),
        .i_data(i_writedata),
        .o_valid(txb_out_vld),
        .i_ready(txb_pop),
        .o_data(txb_data)
    );

    bsp_fifo2 #(.W(32)) u_rx_buf (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(rxb_push),
        .o_ready(rxb_in_rdy),
        .i_data(rx_word),
        .o_valid(rxb_out_vld),
        .i_ready(rxb_pop),
        .o_data(rxb_data)
    );

    // ----------------------------------------------------------------
    // clock and frame pin drivers
    // ----------------------------------------------------------------
    // a clock pin chosen as generator source never drives
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rx_clk_pin <= 1'b0;
            o_rx_clk_oe_n <= 1'b1;
            o_tx_clk_pin <= 1'b0;
            o_tx_clk_oe_n <= 1'b1;
            o_rx_fs_pin <= 1'b0;
            o_rx_fs_oe_n <= 1'b1;
            o_tx_fs_pin <= 1'b0;
            o_tx_fs_oe_n <= 1'b1;
        end else begin
            o_rx_clk_pin <= srg_clk_q ^ pin_q.receive_clock_polarity;
            o_rx_clk_oe_n <= !(pin_q.receive_clock_mode
                && !rx_pin_src);
            o_tx_clk_pin <= srg_clk_q ^ pin_q.transmit_clock_polarity;
            o_tx_clk_oe_n <= !(pin_q.transmit_clock_mode
                && !tx_pin_src);
            o_rx_fs_pin <= fs_gen_q ^ pin_q.receive_frame_polarity;
            o_rx_fs_oe_n <= !pin_q.receive_frame_mode;
            o_tx_fs_pin <= fs_gen_q ^ pin_q.transmit_frame_polarity;
            o_tx_fs_oe_n <= !pin_q.transmit_frame_mode;
        end
    end
endmodule

/* bsp_codec_model.sv */
// behavioural far-side codec: clocks one frame, sends and captures a word
`timescale 1ns/1ps
module bsp_codec_model (
    input wire logic i_go,
    input wire logic [31:0] i_word,
    input wire logic [5:0] i_bits,
    input wire logic i_dev_data,
    output logic o_clk,
    output logic o_fs,
    output logic o_data,
    output logic [31:0] o_word,
    output logic o_busy
);
    // the link clock stands still between frames
    initial begin
        {o_clk, o_fs, o_data, o_busy} = 4'h0;
        o_word = 32'h0;
    end

    // frame pulse for one bit period, then the word msb first
    always @(posedge i_go) begin
        o_busy = 1'b1;
        o_word = 32'h0;
        o_fs = 1'b1;
        #62.5 o_clk = 1'b1;
        #62.5 o_clk = 1'b0;
        o_fs = 1'b0;
        for (int i = int'(i_bits) - 1; i >= 0; i--) begin
            o_data = i_word[i];
            #62.5 o_clk = 1'b1;
            o_word = {o_word[30:0], i_dev_data};
            #62.5 o_clk = 1'b0;
        end
        o_data = ~o_data; // released line must not look held
        o_busy = 1'b0;
    end
endmodule

/* bsp_serial_port_properties.sv */
// concurrent checks on the serial port's bus and pin driver behaviour
`timescale 1ns/1ps
module bsp_serial_port_props
    import bsp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic o_rx_clk_oe_n,
    input wire logic o_tx_clk_oe_n,
    input wire logic o_tx_clk_pin,
    input wire logic o_rx_fs_oe_n
);
    logic [15:0] pin_q;
    logic csm_q;
    logic [1:0] age_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // shadow of the configuration, taken where a write takes effect
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_q <= 16'h0000;
            csm_q <= 1'b0;
        end else if (i_write && !o_waitrequest) begin
            if (i_address == OFS_PIN) pin_q <= i_writedata[15:0];
            if (i_address == OFS_RATE) csm_q <= i_writedata[13];
        end
    end

    // pin drivers are registered, so judge them only once settled
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || (i_write && !o_waitrequest)) age_q <= 2'h0;
        else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end

    AST_WAIT_ONE: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_IDLE_WAIT: assert property (!(i_read || i_write) |=> o_waitrequest)
        else $error("answer without a request");
    AST_READ_ONE: assert property (i_read && o_waitrequest |=> !o_waitrequest)
        else $error("read not answered in one cycle");
    AST_PIN_RO: assert property (i_read && !o_waitrequest && i_address == OFS_PIN
        |-> o_readdata[15:14] == 2'b00 && !o_readdata[6])
        else $error("read-only pin control bits not zero");
    AST_RX_PIN_OFF: assert property (age_q == 2'h3 && pin_q[7] && !csm_q
        |-> o_rx_clk_oe_n)
        else $error("receive clock pin driven while it is the source");
    AST_TX_PIN_OFF: assert property (age_q == 2'h3 && pin_q[7] && csm_q
        |-> o_tx_clk_oe_n)
        else $error("transmit clock pin driven while it is the source");
    AST_TX_DRIVE: assert property (age_q == 2'h3 && pin_q[9]
        && !(pin_q[7] && csm_q) |-> !o_tx_clk_oe_n)
        else $error("generated clock not driven on transmit pin");
    AST_GEN_STOP: assert property (age_q == 2'h3 && !pin_q[7] && !csm_q
        |=> $stable(o_tx_clk_pin))
        else $error("clock moves with the unpinned source selected");
    AST_FS_OE: assert property (age_q == 2'h3
        |-> o_rx_fs_oe_n == !pin_q[10])
        else $error("receive frame driver disagrees with frame mode");
endmodule

bind bsp_serial_port bsp_serial_port_props bsp_serial_port_props_inst (
    .i_clk, .i_rst_n, .i_address, .i_read, .i_write, .i_writedata,
    .o_readdata, .o_waitrequest, .o_rx_clk_oe_n, .o_tx_clk_oe_n,
    .o_tx_clk_pin, .o_rx_fs_oe_n
);

/* bsp_serial_port_tb_top.sv */
// self-checking bench for the buffered serial port
`timescale 1ns/1ps
module bsp_serial_port_tb_top;
    import bsp_pkg::*;
    localparam logic [31:0] TXW = 32'hc3a5e19b;
    localparam logic [31:0] RXW = 32'h6b2d8f47;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic go = 1'b0;
    logic [7:0] i_address = 8'h00;
    logic [31:0] i_writedata = 32'h0, o_readdata, q, dev_w;
    logic o_waitrequest, rck, rck_oe, tck, tck_oe, rfs, rfs_oe, tfs, tfs_oe;
    logic txd, txd_oe, p_clk, p_fs, p_dat, busy;
    logic [5:0] bits = 6'd8;
    logic [32:0] m;
    int error_cnt = 0, compares = 0, w;
    int wl[6] = '{8, 12, 16, 20, 24, 32};
    // pin levels from whichever party has its driver on; the data line reads ~txd while the port releases it
    wire rcw = rck_oe ? p_clk : rck;
    wire tcw = tck_oe ? p_clk : tck;
    wire rfw = rfs_oe ? p_fs : rfs;
    wire tfw = tfs_oe ? p_fs : tfs;
    wire dxw = txd_oe ? ~txd : txd;

    always #2 i_clk = ~i_clk;

    bsp_serial_port bsp_serial_port_inst (
        .i_clk, .i_rst_n, .i_address, .i_read, .i_write, .i_writedata,
        .o_readdata, .o_waitrequest, .i_rx_clk_pin(rcw), .o_rx_clk_pin(rck),
        .o_rx_clk_oe_n(rck_oe), .i_tx_clk_pin(tcw), .o_tx_clk_pin(tck),
        .o_tx_clk_oe_n(tck_oe), .i_rx_fs_pin(rfw), .o_rx_fs_pin(rfs),
        .o_rx_fs_oe_n(rfs_oe), .i_tx_fs_pin(tfw), .o_tx_fs_pin(tfs),
        .o_tx_fs_oe_n(tfs_oe), .i_rx_data_pin(p_dat), .o_tx_data_pin(txd),
        .o_tx_data_oe_n(txd_oe));
    bsp_codec_model bsp_codec_model_inst (.i_go(go), .i_word(RXW),
        .i_bits(bits), .i_dev_data(dxw), .o_clk(p_clk), .o_fs(p_fs),
        .o_data(p_dat), .o_word(dev_w), .o_busy(busy));

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= !wr;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            chk(32'h0, 32'h1);
            finish_test();
        end
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_clk); // keeps a gap so no signal is driven twice
    endtask

    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        bus(0, OFS_PIN, 0);
        chk(q, 32'h0);
        bus(1, OFS_PIN, 32'hffff);
        bus(0, OFS_PIN, 0);
        chk(q & 32'hff8f, 32'h3f8f);
        bus(0, 8'h3c, 0);
        chk(q, 32'h0);
        $display("pin control test done");
        for (int k = 0; k < 8; k++) begin
            bus(0, OFS_RXEN + 8'(4 * k), 0);
            chk(q, 32'h0);
            bus(1, OFS_RXEN + 8'(4 * k), 32'h1111 * (k + 1));
            bus(1, OFS_TXEN + 8'(4 * k), 32'h8421 >> k);
        end
        for (int k = 0; k < 8; k++) begin
            bus(0, OFS_RXEN + 8'(4 * k), 0);
            chk(q, 32'h1111 * (k + 1));
            bus(0, OFS_TXEN + 8'(4 * k), 0);
            chk(q, 32'h8421 >> k);
        end
        $display("channel enable test done");
        for (int i = 1; i < 4; i++) begin
            bus(1, OFS_PIN, {24'h0, i[1], 7'h0} | 32'h0300);
            bus(1, OFS_RATE, {18'h0, i[0], 13'h3});
            repeat (3) @(posedge i_clk);
            chk({31'h0, rck_oe}, {31'h0, i == 2});
            chk({31'h0, tck_oe}, {31'h0, i == 3});
        end
        bus(1, OFS_PIN, 0);
        $display("clock source test done");
        for (int c = 0; c < 6; c++) begin
            m = (33'h1 << wl[c]) - 33'h1;
            bus(1, OFS_WORD, 32'(c));
            bus(1, OFS_TXD, TXW);
            bits <= 6'(wl[c]);
            go <= 1'b1;
            @(posedge i_clk);
            go <= 1'b0;
            w = 0;
            do begin
                @(posedge i_clk);
                w++;
            end while (busy !== 1'b0 && w < 2000);
            if (w >= 2000) begin
                chk(32'h0, 32'h1);
                finish_test();
            end
            chk(dev_w, TXW & m[31:0]);
            bus(0, OFS_STAT, 0);
            chk(q & 32'h2, 32'h2);
            bus(0, OFS_RXD, 0);
            chk(q, RXW & m[31:0]);
            $display("word length %0d test done", wl[c]);
        end
        finish_test();
    end
endmodule
